// ==== intc_regs.vh ====
// Register offsets, fields and constants of the interrupt controller
`ifndef INTC_REGS_VH
`define INTC_REGS_VH
`define NUM_SRC 16
`define SRC_W 4
`define NUM_TRAP 8
`define VEC_TABLE_BASE 24'h00_0004
`define VEC_W 8
`define TRAP_VEC_NUM 8'h00
`define SRC_VEC_BASE 8'h08
`define RESET_ADDR 24'h00_0000
`define LVL_TRAP_BASE 4'h8
`define LVL_MAX_USER 3'h7
`define SOFT_TRAP_MASK 8'h1C
`define OFS_PRIO0 12'h000
`define OFS_PRIO1 12'h004
`define OFS_STATUS 12'h008
`define OFS_CTRL 12'h00C
`define OFS_PEND 12'h010
`define OFS_ACCEPT 12'h014
`define OFS_AUXVEC 12'h018
`define OFS_VECBASE 12'h01C
`define OFS_RESETCFG 12'h020
`define STAT_LVL_LSB 5
`define CTRL_TRAP_BIT 3
`define PRIO_RESET 32'h0000_0000
`define AUX_VEC_RESET 24'h00_0000
`define AUX_RESET_RESET 24'h00_0000
`endif

// ==== src_arbiter.v ====
// Priority arbiter for user sources: level first, lowest index next
`timescale 1ns/1ps
`include "intc_regs.vh"
module src_arbiter (
	// Requests and their levels
	input wire [`NUM_SRC-1:0] req,
	input wire [3*`NUM_SRC-1:0] lvl,
	// Winner
	output reg found,
	output reg [3:0] win_idx,
	output reg [2:0] win_lvl
);
	integer i;
	reg [2:0] l;
	// Scan from high index down so equal levels keep lowest index
	always @* begin
		found = 1'b0;
		win_idx = 4'h0;
		win_lvl = 3'h0;
		l = 3'h0;
		for (i = `NUM_SRC - 1; i >= 0; i = i - 1) begin
			l = lvl[3*i +: 3];
			if (req[i] && l != 3'h0 && l >= win_lvl) begin
				found = 1'b1;
				win_idx = i[3:0];
				win_lvl = l;
			end
		end
	end
endmodule

// ==== trap_arbiter.v ====
// Fixed priority trap selector: position 0 is oscillator fail, highest
`timescale 1ns/1ps
`include "intc_regs.vh"
module trap_arbiter (
	// Trap requests
	input wire [`NUM_TRAP-1:0] req,
	// Winner
	output reg found,
	output reg [2:0] win_idx,
	output reg [3:0] win_lvl
);
	integer i;
	// Lowest table position wins, level counts down from 15
	always @* begin
		found = 1'b0;
		win_idx = 3'h0;
		win_lvl = 4'h0;
		for (i = `NUM_TRAP - 1; i >= 0; i = i - 1) begin
			if (req[i]) begin
				found = 1'b1;
				win_idx = i[2:0];
				win_lvl = 4'hF - i[3:0];
			end
		end
	end
endmodule

// ==== prio_intc.v ====
// Prioritised interrupt controller with APB registers
//
// Summary of operation
// - All source and trap requests merge into one core request
// - Vector table starts at 0x000004: eight traps then source vectors
// - Each vector is a 24-bit handler entry address
// - Exceptions taken while in auxiliary memory use one auxiliary vector
// - Reset clears registers and starts execution at address zero
// - Option moves reset start location into auxiliary memory; here the option clears on reset, so each reset starts at zero
// - Sixteen core levels; accept only strictly greater priority
// - Sources use levels 0-7, traps fixed unique levels 8-15
// - A source at level zero is never taken
// - Low level bits in status word 7:5, top bit control word 3
// - Written low level masks sources at or below it
// - Low level 111 blocks all sources, traps still taken
// - Trap bit set by hardware, software may clear, never set
// - Priority fields in low three bits of nibble, bit 3 reads zero
// - Levels 1 lowest to 7 highest, zero disables
// - Highest level wins, then lowest vector number
// - Only strictly higher level preempts running exception
// - Traps ranked by table position, oscillator fail highest
// - Soft traps take two cycles sampling before acceptance
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "intc_regs.vh"
module prio_intc (
	// Clock and reset
	input wire clk,
	input wire arst_n,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// Request lines
	input wire [`NUM_SRC-1:0] src_req,
	input wire [`NUM_TRAP-1:0] trap_req,
	// Core side
	input wire in_aux_mem,
	input wire ack,
	input wire exc_done,
	output reg core_irq,
	output reg [`VEC_W-1:0] vec_num,
	output reg [23:0] vec_addr,
	output reg [23:0] reset_addr
);
	// Level registers and configuration
	reg [2:0] cpu_level_low_bits;
	reg trap_active_level_bit;
	reg [3*`NUM_SRC-1:0] source_priority_regs;
	// Auxiliary vector and reset relocation
	reg [23:0] aux_vec;
	reg [23:0] aux_reset;
	reg aux_reset_en;
	// Soft trap sampling stages
	reg [`NUM_TRAP-1:0] trap_smp1;
	reg [`NUM_TRAP-1:0] trap_smp2;
	// One nesting level kept; a deeper nest loses the outer level
	reg [3:0] saved_level;
	// Level of the request being accepted, held with the core request
	reg [3:0] acc_lvl;
	wire [3:0] cpu_level;
	wire [`NUM_TRAP-1:0] trap_eff;
	// Arbiter results
	wire s_found;
	wire [3:0] s_idx;
	wire [2:0] s_lvl;
	wire t_found;
	wire [2:0] t_idx;
	wire [3:0] t_lvl;
	// Winning candidate against the current core level
	reg cand;
	reg [3:0] cand_lvl;
	reg [`VEC_W-1:0] cand_vec;
	// Bus decode
	wire wr_acc;
	reg [31:0] next_prdata;

	// Unmapped or unaligned offsets; such writes change nothing
	function bad_addr;
		input [11:0] a;
		begin
			bad_addr = (a > `OFS_RESETCFG) || (a[1:0] != 2'b00);
		end
	endfunction

	// Expand three bit fields into nibbles, bit 3 zero
	function [31:0] pack_nib;
		input [23:0] f;
		integer j;
		begin
			pack_nib = 32'h0000_0000;
			for (j = 0; j < 8; j = j + 1)
				pack_nib[4*j +: 3] = f[3*j +: 3];
		end
	endfunction

	// Pull three bit fields out of nibbles
	function [23:0] unpack_nib;
		input [31:0] w;
		integer j;
		begin
			unpack_nib = 24'h00_0000;
			for (j = 0; j < 8; j = j + 1)
				unpack_nib[3*j +: 3] = w[4*j +: 3];
		end
	endfunction

	// Vector number to entry address, 24-bit words in the table
	function [23:0] vec_to_addr;
		input [`VEC_W-1:0] v;
		begin
			vec_to_addr = `VEC_TABLE_BASE + {15'h0000, v, 1'b0};
		end
	endfunction

	assign cpu_level = {trap_active_level_bit, cpu_level_low_bits};
	// Soft traps go through a two stage sampler, hard traps pass straight
	assign trap_eff = (trap_req & ~`SOFT_TRAP_MASK) |
		(trap_smp2 & `SOFT_TRAP_MASK);
	// Writes land only at the access edge of a mapped offset
	assign wr_acc = psel && penable && pwrite && !bad_addr(paddr);

	src_arbiter u_src (
		.req(src_req),
		.lvl(source_priority_regs),
		.found(s_found),
		.win_idx(s_idx),
		.win_lvl(s_lvl)
	);

	trap_arbiter u_trap (
		.req(trap_eff),
		.found(t_found),
		.win_idx(t_idx),
		.win_lvl(t_lvl)
	);

	// Pick trap over source; both must beat current level.
	// Traps always rank above sources, so checking the trap first
	// is enough; a source only wins when no trap can be taken.
	always @* begin
		cand = 1'b0;
		cand_lvl = 4'h0;
		cand_vec = `TRAP_VEC_NUM;
		if (t_found && t_lvl > cpu_level) begin
			cand = 1'b1;
			cand_lvl = t_lvl;
			cand_vec = `TRAP_VEC_NUM + {5'h00, t_idx};
		end else if (s_found && {1'b0, s_lvl} > cpu_level) begin
			cand = 1'b1;
			cand_lvl = {1'b0, s_lvl};
			cand_vec = `SRC_VEC_BASE + {4'h0, s_idx};
		end
	end

	// Soft trap sampler.
	// A soft trap must stand for two edges before it counts, which
	// costs latency but filters a request that drops at once.
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			trap_smp1 <= 8'h00;
			trap_smp2 <= 8'h00;
		end else begin
			trap_smp1 <= trap_req;
			trap_smp2 <= trap_smp1 & trap_req;
		end
	end

	// Core request and vector presentation.
	// Outside auxiliary memory the address follows the vector every cycle, so the core may
	// fetch it in the same cycle as it accepts the request.
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			core_irq <= 1'b0;
			vec_num <= 8'h00;
			vec_addr <= 24'h00_0000;
		end else begin
			core_irq <= cand;
			vec_num <= cand_vec;
			if (in_aux_mem)
				vec_addr <= aux_vec;
			else
				vec_addr <= vec_to_addr(cand_vec);
		end
	end

	// Level registers; acceptance and software writes.
	// Acceptance wins over a return and a return over a bus write,
	// so a write racing an accept is lost; software retries it.
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cpu_level_low_bits <= 3'h0;
			trap_active_level_bit <= 1'b0;
			saved_level <= 4'h0;
		end else if (ack && core_irq) begin
			saved_level <= cpu_level;
			cpu_level_low_bits <= vec_lvl_low(acc_lvl);
			trap_active_level_bit <= acc_lvl[3];
		end else if (exc_done) begin
			cpu_level_low_bits <= saved_level[2:0];
			trap_active_level_bit <= saved_level[3];
		end else if (wr_acc) begin
			if (paddr == `OFS_STATUS)
				cpu_level_low_bits <= pwdata[`STAT_LVL_LSB +: 3];
			if (paddr == `OFS_CTRL && !pwdata[`CTRL_TRAP_BIT])
				trap_active_level_bit <= 1'b0;
		end
	end

	// Accepted level tracks the candidate in step with core_irq
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			acc_lvl <= 4'h0;
		else
			acc_lvl <= cand_lvl;
	end

	// Low level bits of an accepted four bit level
	function [2:0] vec_lvl_low;
		input [3:0] a;
		begin
			vec_lvl_low = a[2:0];
		end
	endfunction

	// Configuration registers.
	// Bit 3 of each priority nibble is dropped on write, so it
	// always reads back as zero.
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			source_priority_regs <= 48'h0000_0000_0000;
			aux_vec <= `AUX_VEC_RESET;
			aux_reset <= `AUX_RESET_RESET;
			aux_reset_en <= 1'b0;
		end else if (wr_acc) begin
			case (paddr)
			`OFS_PRIO0: begin
				source_priority_regs[23:0] <= unpack_nib(pwdata);
			end
			`OFS_PRIO1: begin
				source_priority_regs[47:24] <= unpack_nib(pwdata);
			end
			`OFS_AUXVEC: begin
				aux_vec <= pwdata[23:0];
			end
			`OFS_RESETCFG: begin
				aux_reset <= pwdata[23:0];
				aux_reset_en <= pwdata[31];
			end
			default: begin
			end
			endcase
		end
	end

	// Reset start address seen by the core.
	// The relocation is a register here, so it is lost on reset and
	// the first start after power-up is always at address zero.
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			reset_addr <= `RESET_ADDR;
		else if (aux_reset_en)
			reset_addr <= aux_reset;
		else
			reset_addr <= `RESET_ADDR;
	end

	// Read mux.
	// Pending shows soft traps after their sampler, as arbitration sees
	// them, not the raw request lines.
	always @* begin
		next_prdata = 32'h0000_0000;
		case (paddr)
		`OFS_PRIO0: next_prdata = pack_nib(source_priority_regs[23:0]);
		`OFS_PRIO1: next_prdata = pack_nib(source_priority_regs[47:24]);
		`OFS_STATUS: next_prdata[`STAT_LVL_LSB +: 3] = cpu_level_low_bits;
		`OFS_CTRL: next_prdata[`CTRL_TRAP_BIT] = trap_active_level_bit;
		`OFS_PEND: next_prdata = {8'h00, trap_eff, src_req};
		`OFS_ACCEPT: next_prdata = {23'h00_0000, core_irq, vec_num};
		`OFS_AUXVEC: next_prdata = {8'h00, aux_vec};
		`OFS_VECBASE: next_prdata = {8'h00, `VEC_TABLE_BASE};
		`OFS_RESETCFG: next_prdata = {aux_reset_en, 7'h00, aux_reset};
		default: next_prdata = 32'h0000_0000;
		endcase
	end

	// APB answer: ready in the access cycle, error on unmapped
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && bad_addr(paddr);
			if (psel && !penable)
				prdata <= next_prdata;
		end
	end
endmodule

// ==== intc_monitor.sv ====
// Port checker for the prioritised interrupt controller
`timescale 1ns/1ps
`include "intc_regs.vh"
module intc_monitor (
	// Clock, reset and bus
	input wire clk,
	input wire arst_n,
	input wire psel,
	input wire penable,
	input wire [11:0] paddr,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	// Requests and core side
	input wire [`NUM_SRC-1:0] src_req,
	input wire [`NUM_TRAP-1:0] trap_req,
	input wire in_aux_mem,
	input wire core_irq,
	input wire [`VEC_W-1:0] vec_num,
	input wire [23:0] vec_addr
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	// Zero wait states, one pulse, only inside an access
	a_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	a_ready_single: assert property (pready |=> !pready)
		else $error("ready too long");
	a_ready_in_access: assert property (pready |-> psel && penable)
		else $error("stray ready");
	a_unmapped_error: assert property (psel && penable && pready &&
		(paddr > 12'h020 || paddr[1:0] != 2'b00) |-> pslverr)
		else $error("no error on bad address");
	// Read data must not drift between accesses
	a_rdata_hold: assert property (!(psel && !penable) |=> $stable(prdata))
		else $error("read data moved");
	a_irq_quiet: assert property (
		(src_req == 0 && trap_req == 0) [*3] |=> !core_irq)
		else $error("request without source");
	a_vec_addr_map: assert property (
		core_irq && !in_aux_mem && !$past(in_aux_mem)
		|-> vec_addr == 24'h00_0004 + {15'h0, vec_num, 1'b0})
		else $error("vector address wrong");
	a_osc_trap_wins: assert property (
		$past(trap_req[0]) && trap_req[0] && core_irq |-> vec_num == 8'h00)
		else $error("top trap not chosen");
endmodule
bind prio_intc intc_monitor u_mon (.clk(clk), .arst_n(arst_n),
	.psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .src_req(src_req),
	.trap_req(trap_req), .in_aux_mem(in_aux_mem), .core_irq(core_irq),
	.vec_num(vec_num), .vec_addr(vec_addr));

// ==== core_model.sv ====
// Behavioural core that accepts requests and returns from handlers
`timescale 1ns/1ps
module core_model (
	// Clock and reset
	input wire clk,
	input wire arst_n,
	// Bench controls
	input wire auto_ack,
	input wire slow,
	input wire done_req,
	// Controller side
	input wire core_irq,
	output reg ack,
	output reg exc_done
);
	reg [2:0] cnt;
	// Settle delay so a stale request is never taken twice
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ack <= 1'b0;
			exc_done <= 1'b0;
			cnt <= 3'h0;
		end else begin
			ack <= 1'b0;
			exc_done <= done_req;
			if (core_irq && auto_ack && !ack) begin
				if (cnt >= (slow ? 3'h5 : 3'h2)) begin
					ack <= 1'b1;
					cnt <= 3'h0;
				end else
					cnt <= cnt + 3'h1;
			end else
				cnt <= 3'h0;
		end
	end
endmodule

// ==== tb.sv ====
// Self-checking bench for the prioritised interrupt controller
`timescale 1ns/1ps
`include "intc_regs.vh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
bad_count++; $display("unexpected at %0t: got %h", $time, a); end end
module tb;
	logic clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic pready, pslverr, er, core_irq, ack, exc_done;
	logic [15:0] src_req = 0;
	logic [7:0] trap_req = 0, vec_num;
	logic in_aux_mem = 0, auto_ack = 0, slow = 0, done_req = 0;
	logic [23:0] vec_addr, reset_addr;
	int bad_count = 0, total_checks = 0;
	prio_intc u_prio_intc (.clk(clk), .arst_n(arst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .src_req(src_req), .trap_req(trap_req),
		.in_aux_mem(in_aux_mem), .ack(ack), .exc_done(exc_done),
		.core_irq(core_irq), .vec_num(vec_num), .vec_addr(vec_addr),
		.reset_addr(reset_addr));
	core_model u_core_model (.clk(clk), .arst_n(arst_n),
		.auto_ack(auto_ack), .slow(slow), .done_req(done_req),
		.core_irq(core_irq), .ack(ack), .exc_done(exc_done));
	initial begin
		forever #25 clk = ~clk;
	end
	task close_out;
		if (bad_count == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Bus cycle; an idle cycle after it keeps drives one per step
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			bad_count++;
			close_out;
		end else begin
			rd = prdata;
			er = pslverr;
			psel <= 0;
			penable <= 0;
			@(posedge clk);
		end
	endtask
	initial begin
		tick(3);
		arst_n <= 1;
		tick(1);
		`CHK(reset_addr, 24'h00_0000)
		apb(1, `OFS_PRIO0, 32'hFFFF_FFFF);
		apb(0, `OFS_PRIO0, 0);
		`CHK(rd, 32'h7777_7777)
		apb(1, `OFS_PRIO0, 32'h0000_0330);
		src_req <= 16'h0001;
		tick(4);
		`CHK(core_irq, 1'b0)
		src_req <= 16'h0007;
		tick(4);
		`CHK(vec_num, 8'h09)
		apb(1, `OFS_STATUS, 32'h0000_0060);
		tick(3);
		`CHK(core_irq, 1'b0)
		apb(1, `OFS_STATUS, 0);
		auto_ack <= 1;
		tick(8);
		auto_ack <= 0;
		`CHK(core_irq, 1'b0)
		apb(0, `OFS_STATUS, 0);
		`CHK(rd, 32'h0000_0060)
		done_req <= 1;
		tick(1);
		done_req <= 0;
		tick(4);
		`CHK(core_irq, 1'b1)
		src_req <= 0;
		apb(1, `OFS_STATUS, 32'h0000_00E0);
		trap_req <= 8'h01;
		slow <= 1;
		tick(3);
		`CHK(vec_num, 8'h00)
		auto_ack <= 1;
		tick(10);
		trap_req <= 0;
		auto_ack <= 0;
		apb(0, `OFS_CTRL, 0);
		`CHK(rd, 32'h0000_0008)
		apb(1, `OFS_CTRL, 0);
		apb(1, `OFS_CTRL, 32'h0000_0008);
		apb(0, `OFS_CTRL, 0);
		`CHK(rd, 32'h0000_0000)
		apb(1, `OFS_AUXVEC, 32'h0000_1234);
		in_aux_mem <= 1;
		trap_req <= 8'h02;
		tick(4);
		`CHK(vec_addr, 24'h00_1234)
		apb(1, `OFS_RESETCFG, 32'h8000_0ABC);
		tick(2);
		`CHK(reset_addr, 24'h00_0ABC)
		trap_req <= 0;
		in_aux_mem <= 0;
		tick(3);
		`CHK(core_irq, 1'b0)
		trap_req <= 8'h08;
		tick(2);
		`CHK(core_irq, 1'b0)
		tick(2);
		`CHK(core_irq, 1'b1)
		`CHK(vec_num, 8'h03)
		`CHK(vec_addr, 24'h00_000A)
		trap_req <= 0;
		apb(0, 12'h024, 0);
		`CHK(er, 1'b1)
		close_out;
	end
endmodule
